//--- rfi_host_model.sv
// host-side model: avalon master that reads and writes the flag registers
`timescale 1ns/1ps
`default_nettype none
module rfi_host_model (
    input wire logic clk,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [3:0] avs_byteenable,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ==========================================================
    // bus master
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0000_0000;
    end
    // status reads after each interrupt are what release the pins
    task automatic access(input logic wr, input logic [7:0] adr, input logic [7:0] wdat,
                          input logic [3:0] be, output logic [7:0] rdat);
        @(posedge clk);
        avs_address <= adr;
        avs_read <= !wr;
        avs_write <= wr;
        avs_byteenable <= be;
        avs_writedata <= {24'h00_0000, wdat};
        // no wait count assumed; only the bench watchdog ends a hang
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released address and data lines never keep the old value; byteenable keeps it
        avs_address <= ~adr;
        avs_writedata <= ~{24'h00_0000, wdat};
    endtask
endmodule // rfi_host_model
`default_nettype wire

//--- rfi_pkg.sv
// shared constants and carrier types for the receiver flag and interrupt block
package rfi_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] RFI_IDX_SYNC_CFG = 6'h29;
    localparam logic [5:0] RFI_IDX_MASK_A = 6'h2a;
    localparam logic [5:0] RFI_IDX_MASK_B = 6'h2b;
    localparam logic [5:0] RFI_IDX_STAT_A = 6'h2c;
    localparam logic [5:0] RFI_IDX_STAT_B = 6'h2d;
    localparam logic [5:0] RFI_IDX_POL_LVL = 6'h2e;
    localparam logic [5:0] RFI_IDX_FMT = 6'h2f;
    // ==========================================================
    // reset values
    localparam logic [7:0] RFI_RST_SYNC_CFG = 8'h0c;
    localparam logic [7:0] RFI_RST_MASK = 8'hff;
    localparam logic [7:0] RFI_RST_POL_LVL = 8'h00;
    localparam logic [2:0] RFI_RST_FMT = 3'h4;
    // ==========================================================
    // field positions
    localparam int RFI_SYNC16_BIT = 3;
    localparam int RFI_SYNC14_BIT = 2;
    localparam int RFI_PERIOD_LSB = 0;
    localparam int RFI_POL_B_BIT = 6;
    localparam int RFI_THR_LSB = 3;
    localparam int RFI_POL_A_BIT = 2;
    localparam int RFI_C_ERROR = 7;
    localparam int RFI_C_NONPCM = 6;
    localparam int RFI_C_EMPH = 5;
    localparam int RFI_C_SYNC = 4;
    localparam int RFI_C_CHSTAT = 3;
    localparam int RFI_C_PREAMBLE = 2;
    localparam int RFI_C_RATE = 1;
    localparam int RFI_C_ADC = 0;
    // ==========================================================
    // output format codes
    localparam logic [2:0] RFI_FMT_RJ24 = 3'h0;
    localparam logic [2:0] RFI_FMT_RJ16 = 3'h3;
    localparam logic [2:0] RFI_FMT_I2S24 = 3'h4;
    localparam logic [2:0] RFI_FMT_LJ24 = 3'h5;
    // adc level thresholds, attenuation below full scale in dB
    localparam logic [6:0] RFI_THR_DB0 = 7'h0c;
    localparam logic [6:0] RFI_THR_DB1 = 7'h18;
    localparam logic [6:0] RFI_THR_DB2 = 7'h24;
    localparam logic [6:0] RFI_THR_DB3 = 7'h30;
    // ==========================================================
    // flags arriving from the receiver core, same clock
    typedef struct packed {
        logic [5:0] err_factor;
        logic [5:0] err_enable;
        logic nonpcm;
        logic emphasis;
        logic sync16_hit;
        logic sync14_hit;
        logic period_tick;
        logic chstat_renew;
        logic preamble_renew;
        logic rate_renew;
    } rfi_rx_flags_s;
    typedef enum {RFI_BUS_IDLE, RFI_BUS_ANSWER} rfi_bus_e;
endpackage

//--- rfi_sync_det.sv
// compressed-audio sync word detection over a selectable number of periods
`timescale 1ns/1ps
`default_nettype none
module rfi_sync_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync16_enable,
    input wire logic sync14_enable,
    input wire logic [1:0] sync_period_sel,
    input wire logic sync16_hit,
    input wire logic sync14_hit,
    input wire logic period_tick,
    output logic detected
);
    import rfi_pkg::*;
    logic hit;
    logic seen;
    logic [2:0] run;
    logic [2:0] next_run;

    function automatic logic [2:0] need_periods(input logic [1:0] sel);
        case (sel)
            2'h1: need_periods = 3'h1;
            2'h2: need_periods = 3'h2;
            default: need_periods = 3'h4;
        endcase
    endfunction

    // ==========================================================
    // pattern selection
    assign hit = (sync16_enable & sync16_hit) | (sync14_enable & sync14_hit);
    assign next_run = (run == 3'h4) ? run : run + 3'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 1'b0;
        end else if (period_tick) begin
            seen <= 1'b0;
        end else if (hit) begin
            seen <= 1'b1;
        end
    end

    // a period without a sync word breaks the run and drops detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 3'h0;
            detected <= 1'b0;
        end else if (period_tick) begin
            if (seen | hit) begin
                run <= next_run;
                if (sync_period_sel != 2'h0 && next_run >= need_periods(sync_period_sel)) begin
                    detected <= 1'b1;
                end
            end else begin
                run <= 3'h0;
                detected <= 1'b0;
            end
        end else if (hit && sync_period_sel == 2'h0) begin
            detected <= 1'b1;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_sync_ignored: assert property (!sync16_enable && !(sync14_enable && sync14_hit) && !period_tick
        && !detected |=> !detected)
        else $error("disabled 16-bit word detected");
    chk_single_word: assert property (sync_period_sel == 2'h0 && hit && !period_tick |=> detected)
        else $error("single sync word not detected");
    chk_period_need: assert property (sync_period_sel == 2'h3 && run < 3'h3 |=> !$rose(detected))
        else $error("four-period detection came too early");
endmodule // rfi_sync_det
`default_nettype wire

//--- rfi_top.sv
// receiver flag and interrupt block with its register slave
//
// Summary of operation
// - 16-bit sync pattern used only when enabled
// - 14-bit sync pattern used only when enabled
// - period code sets needed sync recurrences
// - sync flag reaches pins only when enabled
// - seven causes masked per bit on output a
// - output b adds adc level cause, masked
// - status a read clears output a, bit0 zero
// - status b read clears output b
// - error bit shows selected error conditions
// - non-pcm bit shows configured non-pcm state
// - emphasis bit follows channel status emphasis
// - channel status renewal detected sets bit
// - burst preamble renewal detected sets bit
// - rate calculator renewal sets bit
// - threshold code selects adc level
// - adc bit set when level reaches threshold
// - output a polarity, low active by default
// - output b polarity, low active by default
// - format code selects receiver output format
// - sixteen-bit right-justified code; reserved codes refused
// - error is OR of enabled factors
`timescale 1ns/1ps
`default_nettype none
module rfi_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire rfi_pkg::rfi_rx_flags_s rx_flags,
    input wire logic [6:0] adc_level_db,
    input wire logic compressed_detect_enable,
    output logic irq_out_a,
    output logic irq_out_b,
    output logic multipurpose_out,
    output logic [2:0] rx_output_format
);
    import rfi_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] sync_word_detect_cfg;
    logic [6:0] irq0_cause_mask;
    logic [7:0] irq1_cause_mask;
    logic [7:0] irq_polarity_level_cfg;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
    logic pend_a;
    logic pend_b;
    rfi_bus_e bus_state;

    // ==========================================================
    // decode helpers
    function automatic logic fmt_valid(input logic [2:0] code);
        fmt_valid = (code == RFI_FMT_RJ24) || (code == RFI_FMT_RJ16) ||
                    (code == RFI_FMT_I2S24) || (code == RFI_FMT_LJ24);
    endfunction

    function automatic logic [6:0] thr_db(input logic [1:0] sel);
        case (sel)
            2'h0: thr_db = RFI_THR_DB0;
            2'h1: thr_db = RFI_THR_DB1;
            2'h2: thr_db = RFI_THR_DB2;
            default: thr_db = RFI_THR_DB3;
        endcase
    endfunction

    function automatic logic hit_idx(input logic [7:0] addr, input logic [5:0] idx);
        hit_idx = (addr[7:2] == idx);
    endfunction

    // ==========================================================
    // bus request decode
    logic req;
    logic take;
    logic rd_take;
    logic wr_take;
    logic rd_clear_a;
    logic rd_clear_b;
    logic [7:0] wbyte;

    assign req = avs_read | avs_write;
    assign take = req && bus_state == RFI_BUS_IDLE;
    assign rd_take = take & avs_read;
    assign wr_take = take & avs_write & avs_byteenable[0];
    assign rd_clear_a = rd_take & hit_idx(avs_address, RFI_IDX_STAT_A);
    assign rd_clear_b = rd_take & hit_idx(avs_address, RFI_IDX_STAT_B);
    assign wbyte = avs_writedata[7:0];

    // ==========================================================
    // sync detection
    logic sync_detected;
    logic sync_flag;

    rfi_sync_det u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .sync16_enable(sync_word_detect_cfg[RFI_SYNC16_BIT]),
        .sync14_enable(sync_word_detect_cfg[RFI_SYNC14_BIT]),
        .sync_period_sel(sync_word_detect_cfg[RFI_PERIOD_LSB +: 2]),
        .sync16_hit(rx_flags.sync16_hit),
        .sync14_hit(rx_flags.sync14_hit),
        .period_tick(rx_flags.period_tick),
        .detected(sync_detected)
    );

    // detection is hidden from pins and causes until enabled
    assign sync_flag = sync_detected & compressed_detect_enable;

    // ==========================================================
    // cause levels and events
    logic err_now;
    logic adc_now;
    logic [7:0] lvl;
    logic [7:0] lvl_q;
    logic [7:0] ev;

    assign err_now = |(rx_flags.err_factor & rx_flags.err_enable);
    assign adc_now = adc_level_db <= thr_db(irq_polarity_level_cfg[RFI_THR_LSB +: 2]);

    always_comb begin
        lvl = 8'h00;
        lvl[RFI_C_ERROR] = err_now;
        lvl[RFI_C_NONPCM] = rx_flags.nonpcm;
        lvl[RFI_C_EMPH] = rx_flags.emphasis;
        lvl[RFI_C_SYNC] = sync_flag;
        lvl[RFI_C_ADC] = adc_now;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 8'h00;
        end else begin
            lvl_q <= lvl;
        end
    end

    // levels raise an event on their rising edge so a read can release the pin
    always_comb begin
        ev = lvl & ~lvl_q;
        ev[RFI_C_CHSTAT] = rx_flags.chstat_renew;
        ev[RFI_C_PREAMBLE] = rx_flags.preamble_renew;
        ev[RFI_C_RATE] = rx_flags.rate_renew;
    end

    // ==========================================================
    // masking
    logic [7:0] mask_a;
    logic [7:0] ev_a;
    logic [7:0] ev_b;

    // bit 0 of the first mask has no cause and stays masked
    assign mask_a = {irq0_cause_mask, 1'b1};
    assign ev_a = ev & ~mask_a;
    assign ev_b = ev & ~irq1_cause_mask;

    // ==========================================================
    // sticky status, set wins over the read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_a <= 8'h00;
        end else begin
            lat_a <= (rd_clear_a ? 8'h00 : lat_a) | (ev & 8'hfe);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_b <= 8'h00;
        end else begin
            lat_b <= (rd_clear_b ? 8'h00 : lat_b) | ev;
        end
    end

    // ==========================================================
    // pending interrupt state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_a <= 1'b0;
        end else if (|ev_a) begin
            pend_a <= 1'b1;
        end else if (rd_clear_a) begin
            pend_a <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_b <= 1'b0;
        end else if (|ev_b) begin
            pend_b <= 1'b1;
        end else if (rd_clear_b) begin
            pend_b <= 1'b0;
        end
    end

    // ==========================================================
    // pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_a <= 1'b1;
            irq_out_b <= 1'b1;
            multipurpose_out <= 1'b0;
        end else begin
            irq_out_a <= irq_polarity_level_cfg[RFI_POL_A_BIT] ? pend_a : ~pend_a;
            irq_out_b <= irq_polarity_level_cfg[RFI_POL_B_BIT] ? pend_b : ~pend_b;
            multipurpose_out <= sync_flag;
        end
    end

    // ==========================================================
    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_word_detect_cfg <= RFI_RST_SYNC_CFG;
        end else if (wr_take && hit_idx(avs_address, RFI_IDX_SYNC_CFG)) begin
            sync_word_detect_cfg <= wbyte & 8'h0f;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq0_cause_mask <= RFI_RST_MASK[7:1];
            irq1_cause_mask <= RFI_RST_MASK;
        end else if (wr_take) begin
            if (hit_idx(avs_address, RFI_IDX_MASK_A)) begin
                irq0_cause_mask <= wbyte[7:1];
            end
            if (hit_idx(avs_address, RFI_IDX_MASK_B)) begin
                irq1_cause_mask <= wbyte;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_polarity_level_cfg <= RFI_RST_POL_LVL;
        end else if (wr_take && hit_idx(avs_address, RFI_IDX_POL_LVL)) begin
            irq_polarity_level_cfg <= wbyte & 8'h5c;
        end
    end

    // reserved codes would leave the serial port in an undefined format
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_output_format <= RFI_RST_FMT;
        end else if (wr_take && hit_idx(avs_address, RFI_IDX_FMT) && fmt_valid(wbyte[2:0])) begin
            rx_output_format <= wbyte[2:0];
        end
    end

    // ==========================================================
    // read mux
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (avs_address[7:2])
            RFI_IDX_SYNC_CFG: rd_byte = sync_word_detect_cfg;
            RFI_IDX_MASK_A: rd_byte = mask_a;
            RFI_IDX_MASK_B: rd_byte = irq1_cause_mask;
            RFI_IDX_STAT_A: rd_byte = (lat_a | lvl) & 8'hfe;
            RFI_IDX_STAT_B: rd_byte = lat_b | lvl;
            RFI_IDX_POL_LVL: rd_byte = irq_polarity_level_cfg;
            RFI_IDX_FMT: rd_byte = {5'h00, rx_output_format};
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= RFI_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            case (bus_state)
                RFI_BUS_IDLE: begin
                    if (req) begin
                        bus_state <= RFI_BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                    end
                end
                RFI_BUS_ANSWER: begin
                    bus_state <= RFI_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state <= RFI_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_bus_answer;
        req && bus_state == RFI_BUS_IDLE ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_answer: assert property (req && bus_state == RFI_BUS_IDLE |-> s_bus_answer)
        else $error("bus answer not on the second edge");
    chk_mask_a_gate: assert property (!pend_a && ev_a == 8'h00 |=> !pend_a)
        else $error("masked cause raised output a");
    chk_mask_b_gate: assert property (!pend_b && (ev & ~irq1_cause_mask) == 8'h00 |=> !pend_b)
        else $error("masked cause raised output b");
    chk_pend_hold: assert property (pend_a && !rd_clear_a |=> pend_a)
        else $error("output a released without a status read");
    chk_read_clear_a: assert property (rd_clear_a && ev_a == 8'h00 |=> !pend_a ##1 avs_readdata[0] == 1'b0)
        else $error("status a read did not release output a");
    chk_read_clear_b: assert property (rd_clear_b && ev_b == 8'h00 |=> !pend_b)
        else $error("status b read did not release output b");
    chk_error_seen: assert property (rd_clear_a && (err_now || lat_a[RFI_C_ERROR])
        |=> avs_readdata[RFI_C_ERROR])
        else $error("active error not reported");
    chk_adc_seen: assert property (rd_clear_b && adc_now |=> avs_readdata[RFI_C_ADC])
        else $error("adc level not reported");
    chk_pin_a_pol: assert property (pend_a |=> irq_out_a == irq_polarity_level_cfg[RFI_POL_A_BIT] ||
        $changed(irq_polarity_level_cfg))
        else $error("output a polarity wrong");
    chk_pin_b_pol: assert property (!pend_b && !irq_polarity_level_cfg[RFI_POL_B_BIT] |=> irq_out_b ||
        $changed(irq_polarity_level_cfg))
        else $error("output b idle level wrong");
    chk_fmt_hold: assert property (wr_take && hit_idx(avs_address, RFI_IDX_FMT) && !fmt_valid(wbyte[2:0])
        |=> $stable(rx_output_format))
        else $error("reserved format code accepted");
    chk_sync_gate: assert property (!compressed_detect_enable |=> !multipurpose_out)
        else $error("sync flag shown while disabled");
endmodule // rfi_top
`default_nettype wire

//--- testbench.sv
// self-checking bench for the receiver flag and interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rfi_pkg::*;
    logic clk;
    logic rst_n;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    rfi_rx_flags_s rx_flags;
    logic [6:0] adc_level_db;
    logic compressed_detect_enable;
    logic irq_out_a;
    logic irq_out_b;
    logic multipurpose_out;
    logic [2:0] rx_output_format;
    int error_cnt;
    int compares;
    logic [7:0] exp_q[$];
    string name_q[$];
    // ==========================================================
    // instances
    rfi_top u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_flags(rx_flags),
        .adc_level_db(adc_level_db), .compressed_detect_enable(compressed_detect_enable),
        .irq_out_a(irq_out_a), .irq_out_b(irq_out_b), .multipurpose_out(multipurpose_out),
        .rx_output_format(rx_output_format));
    rfi_host_model u_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================
    // checking
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // read results are judged in arrival order
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(name_q.pop_front(), avs_readdata, {24'h00_0000, exp_q.pop_front()});
        end
    end
    initial begin
        #(25 * 5000);
        error_cnt++;
        stop_test();
    end
    // ==========================================================
    // stimulus helpers
    function automatic logic [7:0] adr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] r;
        u_host.access(1'b1, adr(idx), d, 4'hf, r);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string what);
        logic [7:0] r;
        exp_q.push_back(e);
        name_q.push_back(what);
        u_host.access(1'b0, adr(idx), 8'h00, 4'hf, r);
    endtask
    // one-cycle flag; returns just after the pin may have moved
    task automatic pulse(input rfi_rx_flags_s m);
        @(posedge clk);
        rx_flags <= rx_flags | m;
        @(posedge clk);
        rx_flags <= rx_flags & ~m;
        @(posedge clk);
        #1;
    endtask
    task automatic hit(input rfi_rx_flags_s m, input logic e, input string what);
        logic s;
        s = 1'b0;
        pulse(m);
        repeat (4) begin
            @(posedge clk);
            if (multipurpose_out === 1'b1) begin
                s = 1'b1;
            end
        end
        #1;
        check(what, s, e);
    endtask
    function automatic rfi_rx_flags_s cause(input int b, input int k);
        rfi_rx_flags_s m;
        m = '0;
        case (b)
            RFI_C_ERROR: begin
                m.err_factor[k] = 1'b1;
                m.err_enable[k] = 1'b1;
            end
            RFI_C_NONPCM: m.nonpcm = 1'b1;
            RFI_C_EMPH: m.emphasis = 1'b1;
            RFI_C_CHSTAT: m.chstat_renew = 1'b1;
            RFI_C_PREAMBLE: m.preamble_renew = 1'b1;
            default: m.rate_renew = 1'b1;
        endcase
        return m;
    endfunction
    // ==========================================================
    // tests
    initial begin
        logic [7:0] pol;
        logic [7:0] r;
        logic pa;
        logic pb;
        logic [2:0] fexp;
        int k;
        rfi_rx_flags_s m;
        rst_n = 1'b0;
        rx_flags = '0;
        adc_level_db = 7'h7f;
        compressed_detect_enable = 1'b1;
        error_cnt = 0;
        compares = 0;
        void'($urandom(32'h2058_e24d));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("irq a reset", irq_out_a, 1'b1);
        check("irq b reset", irq_out_b, 1'b1);
        rd(RFI_IDX_SYNC_CFG, 8'h0c, "sync cfg");
        rd(RFI_IDX_MASK_A, 8'hff, "mask a");
        rd(RFI_IDX_MASK_B, 8'hff, "mask b");
        rd(RFI_IDX_STAT_A, 8'h00, "status a");
        rd(RFI_IDX_STAT_B, 8'h00, "status b");
        rd(RFI_IDX_POL_LVL, 8'h00, "pol lvl");
        rd(6'h00, 8'h00, "unmapped");
        $display("test reset done");
        // reserved codes must leave the previous format in place
        fexp = 3'b100;
        for (int c = 0; c < 8; c++) begin
            wr(RFI_IDX_FMT, 8'(c));
            if (c inside {0, 3, 4, 5}) begin
                fexp = 3'(c);
            end
            rd(RFI_IDX_FMT, {5'h00, fexp}, "format");
            check("format port", rx_output_format, fexp);
        end
        u_host.access(1'b1, adr(RFI_IDX_FMT), 8'h00, 4'he, r);
        rd(RFI_IDX_FMT, 8'h05, "format lane off");
        $display("test format done");
        for (int ch = 0; ch < 2; ch++) begin
            for (int b = 1; b < 8; b++) begin
                if (b == RFI_C_SYNC) continue;
                pa = 1'($urandom);
                pb = 1'($urandom);
                k = $urandom % 6;
                pol = {1'b0, pb, 3'b000, pa, 2'b00};
                wr(RFI_IDX_POL_LVL, pol);
                rd(RFI_IDX_POL_LVL, pol, "pol lvl");
                wr(ch ? RFI_IDX_MASK_B : RFI_IDX_MASK_A, ~(8'h01 << b));
                wr(ch ? RFI_IDX_MASK_A : RFI_IDX_MASK_B, 8'hff);
                m = cause(b, k);
                if (b == RFI_C_ERROR) begin
                    m.err_enable = ~m.err_enable;
                    pulse(m);
                    check("irq unselected error", ch ? irq_out_b : irq_out_a, ch ? !pb : !pa);
                    m = cause(b, k);
                end
                pulse(m);
                check("irq a", irq_out_a, ch ? !pa : pa);
                check("irq b", irq_out_b, ch ? pb : !pb);
                rd(ch ? RFI_IDX_STAT_B : RFI_IDX_STAT_A, 8'h01 << b, "status");
                #1;
                check("irq a idle", irq_out_a, !pa);
                check("irq b idle", irq_out_b, !pb);
                rd(ch ? RFI_IDX_STAT_A : RFI_IDX_STAT_B, 8'h01 << b, "masked status");
            end
        end
        $display("test causes done");
        // both sides of every threshold boundary
        for (int t = 0; t < 4; t++) begin
            wr(RFI_IDX_POL_LVL, {3'b000, 2'(t), 3'b000});
            wr(RFI_IDX_MASK_B, 8'hfe);
            @(posedge clk);
            adc_level_db <= 7'(12 * t + 13);
            repeat (3) @(posedge clk);
            #1;
            check("irq b above level", irq_out_b, 1'b1);
            @(posedge clk);
            adc_level_db <= 7'(12 * t + 12);
            repeat (3) @(posedge clk);
            #1;
            check("irq b level", irq_out_b, 1'b0);
            rd(RFI_IDX_STAT_B, 8'h01, "status level");
            @(posedge clk);
            adc_level_db <= 7'h7f;
            rd(RFI_IDX_STAT_B, 8'h00, "status quiet");
        end
        $display("test level done");
        wr(RFI_IDX_MASK_A, 8'hef);
        wr(RFI_IDX_MASK_B, 8'hff);
        wr(RFI_IDX_SYNC_CFG, 8'h04);
        m = '0;
        m.sync16_hit = 1'b1;
        hit(m, 1'b0, "mpo 16-bit off");
        check("irq a no sync", irq_out_a, 1'b1);
        m = '0;
        m.sync14_hit = 1'b1;
        hit(m, 1'b1, "mpo 14-bit");
        check("irq a sync", irq_out_a, 1'b0);
        rd(RFI_IDX_STAT_A, 8'h10, "status sync");
        @(posedge clk);
        compressed_detect_enable <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("mpo gated", multipurpose_out, 1'b0);
        @(posedge clk);
        compressed_detect_enable <= 1'b1;
        for (int c = 1; c < 4; c++) begin
            wr(RFI_IDX_SYNC_CFG, {6'h03, 2'(c)});
            m = '0;
            m.period_tick = 1'b1;
            pulse(m);
            repeat (3) @(posedge clk);
            for (int p = 1; p <= (1 << (c - 1)); p++) begin
                m = '0;
                m.sync16_hit = 1'b1;
                pulse(m);
                m = '0;
                m.period_tick = 1'b1;
                hit(m, p == (1 << (c - 1)), "mpo period");
            end
        end
        $display("test sync done");
        repeat (5) @(posedge clk);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
